// File: core/rps_pin_mux.sv
// Registered pin-to-peripheral multiplexer, one lane per routed input
`timescale 1ns/1ps
module rps_pin_mux
  import rps_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ROUTE_COUNT*SEL_W-1:0] sel,
  input wire logic [PIN_COUNT-1:0] pins,
  output logic [ROUTE_COUNT-1:0] route_level,
  output logic [ROUTE_COUNT-1:0] route_connected
);

  logic [CODE_COUNT-1:0] pins_padded;

  // Codes past the last pin index a zero pad, so the select never leaves the vector
  assign pins_padded = {{(CODE_COUNT - PIN_COUNT){1'b0}}, pins};

  genvar g;
  generate
    for (g = 0; g < ROUTE_COUNT; g++) begin : g_lane
      logic [SEL_W-1:0] code;
      logic hit;
      assign code = sel[g*SEL_W +: SEL_W];
      assign hit = (32'(code) < PIN_COUNT); // [R12]
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          route_level[g] <= UNCONNECTED_LEVEL;
          route_connected[g] <= 1'b0;
        end else begin
          route_level[g] <= hit ? pins_padded[code] : UNCONNECTED_LEVEL; // [R11] [R12] [R13]
          route_connected[g] <= hit;
        end
      end
    end
  endgenerate

endmodule // rps_pin_mux

// File: core/rps_pkg.sv
// Package: register map, field layout, constants and types of the input pin select block
// Operation
// R1: capture5 select register bits 4:0 pick the pin feeding capture channel 5.
// R2: capture5 select register bits 15:5 always read back as zero.
// R3: compare fault select register bits 12:8 pick the pin for fault input B.
// R4: compare fault select register bits 4:0 pick the pin for fault input A.
// R5: serial port 1 select bits 12:8 pick the pin for its clear-to-send input.
// R6: serial port 1 select bits 4:0 pick the pin for its receive input.
// R7: serial port 2 select bits 12:8 pick the pin for its clear-to-send input.
// R8: serial port 2 select bits 4:0 pick the pin for its receive input.
// R9: All implemented select bits are read/write and set to one by reset.
// R10: Dual-field registers read bits 15:13 and 7:5 as zero.
// R11: Each peripheral input receives the level of the pin its field names.
// R12: Code n connects pin n; codes naming no pin leave the input unconnected.
// R13: Writes to unimplemented bits are ignored; routing changes one cycle after the write.
package rps_pkg;

  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam int ADDR_W = 8;
  localparam int REG_W = 16;
  localparam int SEL_W = 5;
  localparam int CODE_COUNT = 2 ** SEL_W;
  localparam int RP_COUNT = 26;
  localparam int RPI_COUNT = 4;
  localparam int PIN_COUNT = RP_COUNT + RPI_COUNT;
  localparam int ROUTE_COUNT = 7;
  localparam int SEL_REG_COUNT = 4;

  localparam logic [ADDR_W-1:0] CAPTURE5_SEL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] FAULT_SEL_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] PORT1_SEL_OFFSET = 8'h08;
  localparam logic [ADDR_W-1:0] PORT2_SEL_OFFSET = 8'h0c;
  localparam logic [ADDR_W-1:0] ROUTE_STATUS_OFFSET = 8'h10;
  localparam logic [ADDR_W-1:0] PIN_LEVEL_OFFSET = 8'h14;
  localparam logic [SEL_REG_COUNT-1:0][ADDR_W-1:0] SEL_OFFSET = {
    PORT2_SEL_OFFSET, PORT1_SEL_OFFSET, FAULT_SEL_OFFSET, CAPTURE5_SEL_OFFSET};

  localparam int LO_FIELD_LSB = 0;
  localparam int HI_FIELD_LSB = 8;
  localparam int STATUS_CONNECTED_LSB = 8;
  localparam logic [REG_W-1:0] SINGLE_FIELD_MASK = 16'h001f;
  localparam logic [REG_W-1:0] DUAL_FIELD_MASK = 16'h1f1f;
  localparam logic [SEL_REG_COUNT-1:0][REG_W-1:0] SEL_MASK = {
    DUAL_FIELD_MASK, DUAL_FIELD_MASK, DUAL_FIELD_MASK, SINGLE_FIELD_MASK};
  localparam logic [REG_W-1:0] SINGLE_FIELD_RESET = 16'h001f;
  localparam logic [REG_W-1:0] DUAL_FIELD_RESET = 16'h1f1f;
  localparam logic [SEL_REG_COUNT-1:0][REG_W-1:0] SEL_RESET = {
    DUAL_FIELD_RESET, DUAL_FIELD_RESET, DUAL_FIELD_RESET, SINGLE_FIELD_RESET};

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic UNCONNECTED_LEVEL = 1'b0;

  // Field order is the route index order, so the packed struct doubles as the mux select vector
  typedef struct packed {
    logic [SEL_W-1:0] port2_cts_pin_field;
    logic [SEL_W-1:0] port2_rx_pin_field;
    logic [SEL_W-1:0] port1_cts_pin_field;
    logic [SEL_W-1:0] port1_rx_pin_field;
    logic [SEL_W-1:0] fault_b_pin_field;
    logic [SEL_W-1:0] fault_a_pin_field;
    logic [SEL_W-1:0] capture5_pin_field;
  } rps_sel_s;

  typedef struct packed {
    logic port2_clear_to_send;
    logic port2_receive;
    logic port1_clear_to_send;
    logic port1_receive;
    logic compare_fault_input_b;
    logic compare_fault_input_a;
    logic input_capture_channel5;
  } rps_route_s;

  typedef enum {WR_COLLECT, WR_COMMIT, WR_RESP} rps_wr_state_e;
  typedef enum {RD_IDLE, RD_RESP} rps_rd_state_e;

endpackage

// File: core/rps_top.sv
// Input pin select block: AXI4-Lite register file and routing of pins to peripheral inputs
`timescale 1ns/1ps
module rps_top
  import rps_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [RP_COUNT-1:0] remappable_pin,
  input wire logic [RPI_COUNT-1:0] remappable_input_only_pin,
  output logic input_capture_channel5,
  output logic compare_fault_input_a,
  output logic compare_fault_input_b,
  output logic port1_receive,
  output logic port1_clear_to_send,
  output logic port2_receive,
  output logic port2_clear_to_send
);

  // Merge one write into a register: only strobed lanes and implemented bits change
  function automatic logic [REG_W-1:0] merge_word(
    input logic [REG_W-1:0] old_word,
    input logic [DATA_W-1:0] data,
    input logic [STRB_W-1:0] strb,
    input logic [REG_W-1:0] mask
  );
    logic [REG_W-1:0] lane_mask;
    lane_mask = {{8{strb[1]}}, {8{strb[0]}}} & mask;
    merge_word = (old_word & ~lane_mask) | (data[REG_W-1:0] & lane_mask);
  endfunction

  rps_wr_state_e wr_state;
  rps_rd_state_e rd_state;

  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [STRB_W-1:0] wr_strb;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_commit;

  logic [SEL_REG_COUNT-1:0][REG_W-1:0] sel_word;
  logic [SEL_REG_COUNT-1:0] wr_hit;
  logic [SEL_REG_COUNT-1:0] rd_hit;
  logic wr_status_hit;
  logic wr_mapped;
  logic rd_mapped;
  logic [DATA_W-1:0] next_rdata;

  rps_sel_s sel;
  rps_route_s route;
  logic [ROUTE_COUNT-1:0] route_level;
  logic [ROUTE_COUNT-1:0] route_connected;
  logic [PIN_COUNT-1:0] pin_bus;

  // Write channels: address and data are taken independently, in either order
  assign s_axi_awready = (wr_state == WR_COLLECT) && !aw_held;
  assign s_axi_wready = (wr_state == WR_COLLECT) && !w_held;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_commit = (wr_state == WR_COMMIT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= WR_COLLECT;
    end else begin
      case (wr_state)
        WR_COLLECT: begin
          if ((aw_held || aw_take) && (w_held || w_take)) begin
            wr_state <= WR_COMMIT;
          end
        end
        WR_COMMIT: begin
          wr_state <= WR_RESP;
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            wr_state <= WR_COLLECT;
          end
        end
        default: begin
          wr_state <= WR_COLLECT;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      wr_addr <= '0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      wr_addr <= s_axi_awaddr;
    end else if (wr_commit) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (w_take) begin
      w_held <= 1'b1;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end else if (wr_commit) begin
      w_held <= 1'b0;
    end
  end

  // Address decode, shared by both directions; low two address bits are ignored
  genvar g;
  generate
    for (g = 0; g < SEL_REG_COUNT; g++) begin : g_sel_reg
      assign wr_hit[g] = (wr_addr[ADDR_W-1:2] == SEL_OFFSET[g][ADDR_W-1:2]);
      assign rd_hit[g] = (s_axi_araddr[ADDR_W-1:2] == SEL_OFFSET[g][ADDR_W-1:2]);

      // Select words hold ones in every field after reset, which is the unconnected code
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sel_word[g] <= SEL_RESET[g]; // [R9]
        end else if (wr_commit && wr_hit[g]) begin
          sel_word[g] <= merge_word(sel_word[g], wr_data, wr_strb, SEL_MASK[g]); // [R9] [R13]
        end
      end
    end
  endgenerate

  assign wr_status_hit = (wr_addr[ADDR_W-1:2] == ROUTE_STATUS_OFFSET[ADDR_W-1:2])
    || (wr_addr[ADDR_W-1:2] == PIN_LEVEL_OFFSET[ADDR_W-1:2]);
  assign wr_mapped = (|wr_hit) || wr_status_hit;

  // Write response; read-only registers accept and drop the data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
  end

  // Field extraction into the select struct
  assign sel.capture5_pin_field = sel_word[0][LO_FIELD_LSB +: SEL_W]; // [R1]
  assign sel.fault_a_pin_field = sel_word[1][LO_FIELD_LSB +: SEL_W]; // [R4]
  assign sel.fault_b_pin_field = sel_word[1][HI_FIELD_LSB +: SEL_W]; // [R3]
  assign sel.port1_rx_pin_field = sel_word[2][LO_FIELD_LSB +: SEL_W]; // [R6]
  assign sel.port1_cts_pin_field = sel_word[2][HI_FIELD_LSB +: SEL_W]; // [R5]
  assign sel.port2_rx_pin_field = sel_word[3][LO_FIELD_LSB +: SEL_W]; // [R8]
  assign sel.port2_cts_pin_field = sel_word[3][HI_FIELD_LSB +: SEL_W]; // [R7]

  // Input-only pins take the codes right after the bidirectional ones
  assign pin_bus = {remappable_input_only_pin, remappable_pin};

  rps_pin_mux u_pin_mux (
    .aclk(aclk),
    .aresetn(aresetn),
    .sel(sel),
    .pins(pin_bus),
    .route_level(route_level),
    .route_connected(route_connected)
  );

  assign route = rps_route_s'(route_level);
  assign input_capture_channel5 = route.input_capture_channel5; // [R11]
  assign compare_fault_input_a = route.compare_fault_input_a; // [R11]
  assign compare_fault_input_b = route.compare_fault_input_b; // [R11]
  assign port1_receive = route.port1_receive; // [R11]
  assign port1_clear_to_send = route.port1_clear_to_send; // [R11]
  assign port2_receive = route.port2_receive; // [R11]
  assign port2_clear_to_send = route.port2_clear_to_send; // [R11]

  // Read channel: one read at a time, data registered at acceptance
  assign s_axi_arready = (rd_state == RD_IDLE);
  assign ar_take = s_axi_arvalid && s_axi_arready;

  always_comb begin
    next_rdata = '0;
    rd_mapped = 1'b1;
    if (rd_hit[0]) begin
      next_rdata[REG_W-1:0] = sel_word[0] & SINGLE_FIELD_MASK; // [R2]
    end else if (rd_hit[1]) begin
      next_rdata[REG_W-1:0] = sel_word[1] & DUAL_FIELD_MASK; // [R10]
    end else if (rd_hit[2]) begin
      next_rdata[REG_W-1:0] = sel_word[2] & DUAL_FIELD_MASK; // [R10]
    end else if (rd_hit[3]) begin
      next_rdata[REG_W-1:0] = sel_word[3] & DUAL_FIELD_MASK; // [R10]
    end else if (s_axi_araddr[ADDR_W-1:2] == ROUTE_STATUS_OFFSET[ADDR_W-1:2]) begin
      next_rdata[ROUTE_COUNT-1:0] = route_level;
      next_rdata[STATUS_CONNECTED_LSB +: ROUTE_COUNT] = route_connected;
    end else if (s_axi_araddr[ADDR_W-1:2] == PIN_LEVEL_OFFSET[ADDR_W-1:2]) begin
      next_rdata[PIN_COUNT-1:0] = pin_bus;
    end else begin
      rd_mapped = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= RD_IDLE;
    end else begin
      case (rd_state)
        RD_IDLE: begin
          if (ar_take) begin
            rd_state <= RD_RESP;
          end
        end
        RD_RESP: begin
          if (s_axi_rready) begin
            rd_state <= RD_IDLE;
          end
        end
        default: begin
          rd_state <= RD_IDLE;
        end
      endcase
    end
  end

  // Read data holds until the master takes it, so later pin changes do not tear the word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
  end

endmodule // rps_top

// File: tb/rps_checker.sv
// Checker: bus answer timing and routing state of the pin select block
`timescale 1ns/1ps
module rps_checker
  import rps_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic input_capture_channel5,
  input wire logic compare_fault_input_a,
  input wire logic compare_fault_input_b,
  input wire logic port1_receive,
  input wire logic port1_clear_to_send,
  input wire logic port2_receive,
  input wire logic port2_clear_to_send
);
  logic [6:0] outs;
  assign outs = {port2_clear_to_send, port2_receive, port1_clear_to_send, port1_receive,
    compare_fault_input_b, compare_fault_input_a, input_capture_channel5};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer off time");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  a_unmapped_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == '0)
    else $error("refused read carries data");
  a_reset_quiet: assert property ($rose(aresetn) |-> outs == '0 ##1 outs == '0)
    else $error("routed input live after reset");
endmodule // rps_checker

// File: tb/rps_pin_model.sv
// Partner model: device pins driven from a bench pattern
`timescale 1ns/1ps
module rps_pin_model
  import rps_pkg::*;
(
  input wire logic aclk,
  input wire logic [PIN_COUNT-1:0] pat,
  output logic [RP_COUNT-1:0] remappable_pin,
  output logic [RPI_COUNT-1:0] remappable_input_only_pin
);
  // Pins move just after an edge, as a synchronised pad would
  always_ff @(posedge aclk) begin
    {remappable_input_only_pin, remappable_pin} <= pat;
  end
endmodule // rps_pin_model

// File: tb/test_rps_top.sv
// Testbench: register access and pin routing of the input pin select block
`timescale 1ns/1ps
module test_rps_top;
  import rps_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [DATA_W-1:0] s_axi_wdata = '0;
  logic [STRB_W-1:0] s_axi_wstrb = '1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [DATA_W-1:0] s_axi_rdata, rd;
  logic [RP_COUNT-1:0] remappable_pin;
  logic [RPI_COUNT-1:0] remappable_input_only_pin;
  logic input_capture_channel5, compare_fault_input_a, compare_fault_input_b;
  logic port1_receive, port1_clear_to_send, port2_receive, port2_clear_to_send;
  logic [PIN_COUNT-1:0] pat = '0;
  logic [31:0] seed = 32'h4a2ef270;
  logic [REG_W-1:0] sh [SEL_REG_COUNT];
  logic [4:0] cor [6] = '{5'h00, 5'h19, 5'h1a, 5'h1d, 5'h1e, 5'h1f};
  int err_total = 0, cmp_count = 0;
  wire logic [6:0] outs = {port2_clear_to_send, port2_receive, port1_clear_to_send, port1_receive,
    compare_fault_input_b, compare_fault_input_a, input_capture_channel5};

  rps_top u_dut (.*);
  rps_pin_model u_pins (.*);

  always #20 aclk = ~aclk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Unconnected codes must read back the fixed idle level, never a stale pin
  function automatic logic [6:0] exp_outs(input logic [PIN_COUNT-1:0] p);
    logic [4:0] c;
    exp_outs = '0;
    for (int r = 0; r < ROUTE_COUNT; r++) begin
      c = 5'(sh[(r + 1) / 2] >> ((r != 0 && r % 2 == 0) ? 8 : 0));
      exp_outs[r] = (c < PIN_COUNT) ? p[c] : UNCONNECTED_LEVEL;
    end
  endfunction

  // Status word: routed levels in the low bits, connected flags from the connected field up
  function automatic logic [31:0] exp_status(input logic [PIN_COUNT-1:0] p);
    logic [4:0] c;
    exp_status = 32'(exp_outs(p));
    for (int r = 0; r < ROUTE_COUNT; r++) begin
      c = 5'(sh[(r + 1) / 2] >> ((r != 0 && r % 2 == 0) ? 8 : 0));
      exp_status[STATUS_CONNECTED_LSB + r] = (c < PIN_COUNT);
    end
  endfunction

  task automatic results;
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // A seed bit holds bready or rready back until the answer shows, so answers must stand
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr && !seed[9];
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr && !seed[9];
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (wr ? (s_axi_bvalid && s_axi_bready) : (s_axi_rvalid && s_axi_rready)) begin
        rsp = wr ? s_axi_bresp : s_axi_rresp;
        rd = s_axi_rdata;
        s_axi_bready <= 0;
        s_axi_rready <= 0;
        return;
      end
      if (wr ? s_axi_bvalid : s_axi_rvalid) begin
        s_axi_bready <= wr;
        s_axi_rready <= !wr;
      end
    end
    err_total++;
    results();
  endtask

  initial begin
    logic [REG_W-1:0] w;
    int i;
    int sft;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    for (int j = 0; j < SEL_REG_COUNT; j++) begin
      sh[j] = SEL_RESET[j];
      bus(0, SEL_OFFSET[j], '0);
      chk(rd, 32'(SEL_RESET[j]));
    end
    @(negedge aclk);
    chk(32'(outs), '0);
    for (int k = 0; k < 8; k++) begin
      for (int j = 0; j < SEL_REG_COUNT; j++) begin
        seed = xs(seed);
        bus(1, SEL_OFFSET[j], seed);
        sh[j] = seed[15:0] & SEL_MASK[j];
        chk(32'(rsp), 32'(RESP_OKAY));
        bus(0, SEL_OFFSET[j], '0);
        chk(rd, 32'(sh[j]));
      end
    end
    for (int r = 0; r < ROUTE_COUNT; r++) begin
      for (int k = 0; k < 8; k++) begin
        seed = xs(seed);
        i = (r + 1) / 2;
        sft = (r != 0 && r % 2 == 0) ? 8 : 0;
        // Junk in the unimplemented bits must not disturb routing
        w = seed[31:16] | DUAL_FIELD_MASK;
        w[sft +: 5] = (k < 6) ? cor[k] : seed[4:0];
        bus(1, SEL_OFFSET[i], {16'h0000, w});
        sh[i] = w & SEL_MASK[i];
        @(negedge aclk);
        chk(32'(outs), 32'(exp_outs(pat)));
        @(posedge aclk);
        pat <= seed[PIN_COUNT-1:0] ^ 30'(seed >> 7);
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk(32'(outs), 32'(exp_outs(pat)));
        bus(0, ROUTE_STATUS_OFFSET, '0);
        chk(rd, exp_status(pat));
        bus(0, PIN_LEVEL_OFFSET, '0);
        chk(rd, 32'(pat));
      end
    end
    // Reset in mid-run must bring every field back to the unconnected code
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    for (int j = 0; j < SEL_REG_COUNT; j++) begin
      sh[j] = SEL_RESET[j];
      bus(0, SEL_OFFSET[j], '0);
      chk(rd, 32'(SEL_RESET[j]));
    end
    @(negedge aclk);
    chk(32'(outs), '0);
    bus(1, ROUTE_STATUS_OFFSET, seed);
    chk(32'(rsp), 32'(RESP_OKAY));
    bus(0, ROUTE_STATUS_OFFSET, '0);
    chk(rd, exp_status(pat));
    bus(1, PIN_LEVEL_OFFSET + 8'h04, seed);
    chk(32'(rsp), 32'(RESP_SLVERR));
    bus(0, PIN_LEVEL_OFFSET + 8'h04, '0);
    chk(32'(rsp), 32'(RESP_SLVERR));
    chk(rd, '0);
    results();
  end
endmodule // test_rps_top

bind rps_top rps_checker u_chk (.*);
